// >>> core/ewdt_top.sv
// Guard timer: AXI4-Lite control register, mode logic, oscillator sync
`timescale 1ns/100ps
`include "ewdt_map.svh"
// Behaviour
// R1: Timeout in interrupt mode sets flag bit 7
// R2: Flag cleared by vector or writing one
// R3: Interrupt requested when global, enable, flag set
// R4: Enable without reset: periodic interrupts only
// R5: Both enables: first timeout sets flag
// R6: Vector in combined mode clears enable, flag
// R7: Unserviced flag at next timeout resets system
// R8: Software re-arms enable after each interrupt
// R9: Mode table; fuse forces reset mode
// R10: Reset-enable clear, period change need unlock
// R11: Unlock bit self-clears four cycles later
// R12: Reset cause flag forces reset enable
// R13: Software clears cause flag before reset enable
// R14: Period 2048 shl code; codes 10-15 reserved
// R15: Control register layout at 0x60
// R16: Software restarts counter before period change
// R17: Init software clears cause flag, reset enable
// R18: Unlock write then update within four cycles
// R19: Counter counts dedicated oscillator cycles
// R20: Fuse locks reset enable 1, irq enable 0
// R21: Restart instruction zeroes the counter
// R22: Interrupt-only timeout restarts and keeps running
module ewdt_top import ewdt_pkg::*; (
    input wire logic aclk, // System clock, 40 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic clk_en, // Clock enable, freezes all state
    input wire logic osc_clk_pin, // Watchdog oscillator, asynchronous
    input wire logic always_on_fuse, // Fuse programmed = 1
    input wire logic timeout_reset_cause_flag, // Reset cause flag from status reg
    input wire logic global_irq_enable, // Global interrupt enable of the core
    input wire logic irq_vector_ack, // Pulse: core executes the watchdog vector
    input wire logic restart_cmd, // Pulse: restart instruction executed
    output logic irq_req, // Interrupt request level
    output logic sys_reset_req, // One-cycle system reset pulse
    input wire logic [`EWDT_ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [`EWDT_ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready // Read data ready
);
    // ------------------------------------------------------------
    // Oscillator synchroniser and edge detect
    // ------------------------------------------------------------
    logic osc_s1_reg;
    logic osc_s2_reg;
    logic osc_s3_reg;
    logic osc_tick;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_s3_reg <= 1'b0;
        end else if (clk_en) begin
            osc_s1_reg <= osc_clk_pin;
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
        end
    end
    // Oscillator is far slower than aclk, so rising edges are never missed
    assign osc_tick = osc_s2_reg & ~osc_s3_reg; // [R19]

    // ------------------------------------------------------------
    // Control register state
    // ------------------------------------------------------------
    logic irq_flag_reg;
    logic irq_en_reg;
    logic rst_en_reg;
    logic [3:0] psel_reg;
    logic [2:0] unlock_cnt_reg;
    logic rst_en_eff;
    logic irq_en_eff;
    logic unlock;
    ewdt_mode_t mode;
    ewdt_tick_if lnk ();

    // Fuse and cause flag dominate whatever was written
    assign rst_en_eff = always_on_fuse | timeout_reset_cause_flag | rst_en_reg; // [R12] [R20]
    assign irq_en_eff = irq_en_reg & ~always_on_fuse; // [R20]
    assign unlock = (unlock_cnt_reg != 3'h0);
    assign mode = always_on_fuse ? EWDT_RESET : // [R9]
                  (rst_en_eff && irq_en_eff) ? EWDT_BOTH :
                  rst_en_eff ? EWDT_RESET :
                  irq_en_eff ? EWDT_IRQ : EWDT_STOPPED;

    assign lnk.running = (mode != EWDT_STOPPED);
    assign lnk.restart = restart_cmd; // [R21]
    assign lnk.period_select = psel_reg;

    ewdt_counter u_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .osc_tick(osc_tick),
        .lnk(lnk)
    );

    // ------------------------------------------------------------
    // Time-out actions
    // ------------------------------------------------------------
    logic timeout_set_flag;
    logic timeout_reset;
    logic sys_reset_reg;

    // Combined mode with a pending flag means the interrupt went unserviced
    assign timeout_set_flag = lnk.timeout && (mode == EWDT_IRQ || // [R1] [R4]
                              (mode == EWDT_BOTH && !irq_flag_reg)); // [R5]
    assign timeout_reset = lnk.timeout && (mode == EWDT_RESET || // [R9]
                           (mode == EWDT_BOTH && irq_flag_reg)); // [R7]
    assign irq_req = global_irq_enable & irq_en_eff & irq_flag_reg; // [R3]
    assign sys_reset_req = sys_reset_reg;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic aw_held_reg;
    logic w_held_reg;
    logic [`EWDT_ADDR_W-1:0] awaddr_reg;
    logic [7:0] wdata_reg;
    logic wstrb0_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic wr_fire;
    logic wr_hit;
    logic rd_fire;
    logic rd_hit;
    logic [7:0] ctrl_rd;
    logic [7:0] wd;
    logic psel_change;
    logic rst_en_clear;
    logic wr_ok;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_hit = (awaddr_reg == `EWDT_CTRL_OFS);
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign rd_fire = s_axi_arvalid && !rvalid_reg;
    assign rd_hit = (s_axi_araddr == `EWDT_CTRL_OFS);
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    assign ctrl_rd = {irq_flag_reg, irq_en_eff, psel_reg[3], unlock, // [R15]
                      rst_en_eff, psel_reg[2:0]};

    // Protected fields: clearing reset enable or changing the period
    assign wd = wdata_reg;
    assign psel_change = {wd[`EWDT_BIT_PSEL3], wd[2:0]} != psel_reg;
    assign rst_en_clear = !wd[`EWDT_BIT_RST_EN];
    assign wr_ok = wr_fire && wr_hit && wstrb0_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `EWDT_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata[7:0];
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? `EWDT_RESP_OKAY : `EWDT_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `EWDT_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else if (clk_en) begin
            if (rd_fire) begin
                rvalid_reg <= 1'b1;
                rresp_reg <= rd_hit ? `EWDT_RESP_OKAY : `EWDT_RESP_SLVERR;
                rdata_reg <= rd_hit ? {24'h000000, ctrl_rd} : 32'h0000_0000;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Register updates
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_flag_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            rst_en_reg <= 1'b0;
            psel_reg <= 4'h0;
            unlock_cnt_reg <= 3'h0;
            sys_reset_reg <= 1'b0;
        end else if (clk_en) begin
            sys_reset_reg <= timeout_reset; // [R7] [R9]
            if (unlock) begin
                unlock_cnt_reg <= unlock_cnt_reg - 3'h1; // [R11]
            end
            if (wr_ok) begin
                irq_en_reg <= wd[`EWDT_BIT_IRQ_EN];
                // Unlock needs reset enable written too, so a stray write cannot open it
                if (wd[`EWDT_BIT_UNLOCK] && wd[`EWDT_BIT_RST_EN]) begin
                    unlock_cnt_reg <= `EWDT_UNLOCK_CYCLES; // [R11] [R18]
                end else if (!wd[`EWDT_BIT_UNLOCK]) begin
                    unlock_cnt_reg <= 3'h0;
                end
                if (!rst_en_clear) begin
                    rst_en_reg <= 1'b1;
                end else if (unlock) begin
                    rst_en_reg <= 1'b0; // [R10]
                end
                if (psel_change && unlock) begin
                    psel_reg <= {wd[`EWDT_BIT_PSEL3], wd[2:0]}; // [R10]
                end
            end
            // Vector in combined mode drops back to reset-only mode
            if (irq_vector_ack && mode == EWDT_BOTH) begin
                irq_en_reg <= 1'b0; // [R6]
            end
            // Set wins over either clear
            if (timeout_set_flag) begin
                irq_flag_reg <= 1'b1; // [R1] [R5]
            end else if (irq_vector_ack || (wr_ok && wd[`EWDT_BIT_IRQ_FLAG])) begin
                irq_flag_reg <= 1'b0; // [R2] [R6]
            end
        end
    end
endmodule : ewdt_top

// >>> common/ewdt_map.svh
// Register map, field positions and timing counts of the guard timer
`ifndef EWDT_MAP_SVH
`define EWDT_MAP_SVH
`define EWDT_CTRL_OFS 8'h60
`define EWDT_ADDR_W 8
`define EWDT_BIT_IRQ_FLAG 7
`define EWDT_BIT_IRQ_EN 6
`define EWDT_BIT_PSEL3 5
`define EWDT_BIT_UNLOCK 4
`define EWDT_BIT_RST_EN 3
`define EWDT_CTRL_RESET 8'h00
`define EWDT_UNLOCK_CYCLES 3'h4
`define EWDT_BASE_SHIFT 11
`define EWDT_PSEL_MAX 4'h9
`define EWDT_CNT_W 21
`define EWDT_RESP_OKAY 2'h0
`define EWDT_RESP_SLVERR 2'h2
`endif

// >>> common/ewdt_pkg.sv
// Types shared by the guard timer modules
package ewdt_pkg;
    typedef enum logic [1:0] {EWDT_STOPPED, EWDT_IRQ, EWDT_RESET, EWDT_BOTH} ewdt_mode_t;
endpackage : ewdt_pkg

// >>> common/ewdt_tick_if.sv
// Link between control logic and the oscillator-side counter
`timescale 1ns/100ps
interface ewdt_tick_if;
    logic running;
    logic restart;
    logic [3:0] period_select;
    logic timeout;
    modport ctrl (output running, output restart, output period_select, input timeout);
    modport cnt (input running, input restart, input period_select, output timeout);
endinterface : ewdt_tick_if

// >>> core/ewdt_counter.sv
// Guard timer counter of oscillator ticks with period decode
`timescale 1ns/100ps
`include "ewdt_map.svh"
module ewdt_counter import ewdt_pkg::*; (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic clk_en, // Freezes state while low
    input wire logic osc_tick, // One pulse per oscillator cycle, same domain
    ewdt_tick_if.cnt lnk // Control link
);
    logic [`EWDT_CNT_W-1:0] cnt_reg;
    logic [`EWDT_CNT_W-1:0] cnt_next;
    logic to_reg;
    logic [`EWDT_CNT_W-1:0] limit;

    // Period in oscillator cycles: 2048 shifted by the code; reserved codes clamp
    function automatic logic [`EWDT_CNT_W-1:0] ewdt_limit(input logic [3:0] code);
        logic [3:0] c;
        c = (code > `EWDT_PSEL_MAX) ? `EWDT_PSEL_MAX : code;
        return `EWDT_CNT_W'(1) << (`EWDT_BASE_SHIFT + 32'(c));
    endfunction : ewdt_limit

    assign limit = ewdt_limit(lnk.period_select); // [R14]
    // Comparison is >= so a switch to a period shorter than the current count times out on the next oscillator tick
    assign cnt_next = (cnt_reg + `EWDT_CNT_W'(1) >= limit) ? '0 : cnt_reg + `EWDT_CNT_W'(1);
    assign lnk.timeout = to_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= '0;
            to_reg <= 1'b0;
        end else if (clk_en) begin
            to_reg <= 1'b0;
            if (lnk.restart || !lnk.running) begin
                cnt_reg <= '0; // [R21]
            end else if (osc_tick) begin
                cnt_reg <= cnt_next; // [R19] [R22]
                to_reg <= (cnt_next == '0);
            end
        end
    end
endmodule : ewdt_counter

// >>> verification/ewdt_props.sv
// Port-level assertions for the guard timer
`timescale 1ns/100ps
module ewdt_props (
    input wire logic aclk, // clk
    input wire logic aresetn, // rst
    input wire logic global_irq_enable, // in
    input wire logic irq_vector_ack, // in
    input wire logic irq_req, // out
    input wire logic sys_reset_req, // out
    input wire logic s_axi_awvalid, // in
    input wire logic s_axi_awready, // out
    input wire logic s_axi_wvalid, // in
    input wire logic s_axi_wready, // out
    input wire logic s_axi_bvalid, // out
    input wire logic s_axi_bready, // in
    input wire logic s_axi_arvalid, // in
    input wire logic s_axi_arready, // out
    input wire logic s_axi_rvalid, // out
    input wire logic s_axi_rready // in
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_irq_gate: assert property (irq_req |-> global_irq_enable)
        else $error("irq request without global enable");
    a_vector_clears: assert property (irq_req && irq_vector_ack |=> !irq_req)
        else $error("vector did not drop the irq request");
    a_reset_pulse: assert property (sys_reset_req |=> !sys_reset_req)
        else $error("system reset longer than one cycle");
    a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not retired");
    a_rdata_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not retired");
    a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
endmodule : ewdt_props
bind ewdt_top ewdt_props chk_u (.aclk, .aresetn, .global_irq_enable, .irq_vector_ack,
    .irq_req, .sys_reset_req, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready);

// >>> verification/ewdt_osc_model.sv
// Free-running model of the guard timer oscillator
`timescale 1ns/100ps
module ewdt_osc_model (
    output logic osc_clk // Oscillator output
);
    // Exactly four aclk periods per tick keeps time-out spacing exact
    initial begin
        osc_clk = 1'b0;
        #3.3;
        forever #50 osc_clk = ~osc_clk;
    end
endmodule : ewdt_osc_model

// >>> verification/testbench.sv
// Self-checking bench for the guard timer
`timescale 1ns/100ps
`include "ewdt_map.svh"
module testbench;
    localparam int TOUT = (1 << `EWDT_BASE_SHIFT) * 4; // Four aclk cycles per tick
    localparam logic [7:0] CTRL = `EWDT_CTRL_OFS;
    localparam logic [1:0] OK = `EWDT_RESP_OKAY;
    logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, always_on_fuse = 1'b0;
    logic timeout_reset_cause_flag = 1'b0, global_irq_enable = 1'b0;
    logic irq_vector_ack = 1'b0, restart_cmd = 1'b0, s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic osc_clk_pin, irq_req, sys_reset_req, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    int n_mismatch = 0, checks_done = 0, n_rst = 0;
    always #12.5 aclk = ~aclk;
    always @(posedge aclk) if (sys_reset_req === 1'b1) n_rst++;
    ewdt_osc_model osc_u (.osc_clk(osc_clk_pin));
    ewdt_top dut_u (.aclk, .aresetn, .clk_en, .osc_clk_pin, .always_on_fuse,
        .timeout_reset_cause_flag, .global_irq_enable, .irq_vector_ack, .restart_cmd,
        .irq_req, .sys_reset_req, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    task automatic conclude();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic fail_out();
        n_mismatch++;
        $display("[FAIL] %0t wait ran out", $time);
        conclude();
    endtask : fail_out
    // Each valid drops once its ready is seen, so back-to-back calls never drive a transfer twice
    task automatic wr(input logic [7:0] a, input logic [7:0] v,
                      input logic [1:0] er = `EWDT_RESP_OKAY);
        bit done;
        done = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 40 && !done; i++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                done = 1;
                check({30'h0, s_axi_bresp}, {30'h0, er});
            end
        end
        if (!done) fail_out();
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        bit done;
        done = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 40 && !done; i++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                done = 1;
                check(s_axi_rdata, exp);
                check({30'h0, s_axi_rresp}, {30'h0, er});
            end
        end
        if (!done) fail_out();
    endtask : rd_chk
    task automatic wait_hi(input bit rst, input int lim);
        for (int i = 0; (rst ? sys_reset_req : irq_req) !== 1'b1; i++) begin
            if (i == lim) fail_out();
            @(posedge aclk);
        end
    endtask : wait_hi
    task automatic do_reset();
        aresetn <= 1'b0;
        always_on_fuse <= 1'b0;
        global_irq_enable <= 1'b0;
        timeout_reset_cause_flag <= 1'b0;
        n_rst = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : do_reset
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_regs();
        rd_chk(CTRL, 32'h0, OK);
        rd_chk(8'h64, 32'h0, `EWDT_RESP_SLVERR);
        wr(8'h64, 8'h48, `EWDT_RESP_SLVERR);
        rd_chk(CTRL, 32'h0, OK);
        // A write without its low byte lane must leave the register alone
        s_axi_wstrb <= 4'h0;
        wr(CTRL, 8'h48);
        s_axi_wstrb <= 4'hf;
        rd_chk(CTRL, 32'h0, OK);
        wr(CTRL, 8'h27);
        rd_chk(CTRL, 32'h0, OK);
        timeout_reset_cause_flag <= 1'b1;
        wr(CTRL, 8'h00);
        rd_chk(CTRL, 32'h08, OK);
        timeout_reset_cause_flag <= 1'b0;
        wr(CTRL, 8'h08);
        wr(CTRL, 8'h18);
        rd_chk(CTRL, 32'h18, OK);
        repeat (8) @(posedge aclk);
        rd_chk(CTRL, 32'h08, OK);
        wr(CTRL, 8'h00);
        rd_chk(CTRL, 32'h08, OK);
        restart_cmd <= 1'b1;
        @(posedge aclk);
        restart_cmd <= 1'b0;
        wr(CTRL, 8'h18);
        wr(CTRL, 8'h05);
        rd_chk(CTRL, 32'h05, OK);
    endtask : sc_regs
    task automatic sc_irq();
        time t0;
        global_irq_enable <= 1'b1;
        wr(CTRL, 8'h40);
        wait_hi(0, TOUT + 100);
        t0 = $time;
        rd_chk(CTRL, 32'hc0, OK);
        global_irq_enable <= 1'b0;
        repeat (2) @(posedge aclk);
        check({31'h0, irq_req}, 32'h0);
        global_irq_enable <= 1'b1;
        wr(CTRL, 8'hc0);
        rd_chk(CTRL, 32'h40, OK);
        wait_hi(0, TOUT);
        check(32'(($time - t0) / 25), TOUT);
        check(n_rst, 0);
    endtask : sc_irq
    task automatic sc_comb();
        global_irq_enable <= 1'b1;
        wr(CTRL, 8'h48);
        wait_hi(0, TOUT + 100);
        check(n_rst, 0);
        wait_hi(1, TOUT);
        check({31'h0, irq_req}, 32'h1);
        irq_vector_ack <= 1'b1;
        @(posedge aclk);
        irq_vector_ack <= 1'b0;
        rd_chk(CTRL, 32'h08, OK);
        wr(CTRL, 8'h48);
        rd_chk(CTRL, 32'h48, OK);
    endtask : sc_comb
    task automatic sc_fuse();
        always_on_fuse <= 1'b1;
        wr(CTRL, 8'h40);
        rd_chk(CTRL, 32'h08, OK);
        repeat (3) begin
            repeat (TOUT * 3 / 4) @(posedge aclk);
            restart_cmd <= 1'b1;
            @(posedge aclk);
            restart_cmd <= 1'b0;
        end
        check(n_rst, 0);
        // Frozen for a full period: no reset may come while the enable is low
        clk_en <= 1'b0;
        repeat (TOUT) @(posedge aclk);
        clk_en <= 1'b1;
        check(n_rst, 0);
        wait_hi(1, TOUT + 100);
    endtask : sc_fuse
    initial begin
        do_reset();
        sc_regs();
        do_reset();
        sc_irq();
        do_reset();
        sc_comb();
        do_reset();
        sc_fuse();
        conclude();
    end
endmodule : testbench
